// File: rtl/cpu_power_mode_control.sv
// Processor light and deep sleep control with wake and reset exits
`timescale 1ns/1ps
`include "pwr_mode_regs.svh"
// Contract
// - Light sleep gates only CPU clock
// - Light sleep keeps registers and memory
// - Enabled interrupt or reset ends light
// - Interrupt serviced, then resume next instruction
// - Reset exit restarts fetch at zero
// - Watchdog timeout resets out of light
// - Deep sleep stops CPU and oscillators
// - Only reset ends deep sleep
// - Missing clock detector resets deep sleep
// - Sleep select bits always read zero
// - Top bit doubles serial baud rate
// - Bits six to two are flags
module cpu_power_mode_control
    import pwr_mode_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Register port, write taken when instruction completes
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Interrupt controller and reset sources
    input  wire logic       irq_pending,
    input  wire logic       reset_pin,
    input  wire logic       watchdog_timer_en,
    input  wire logic       watchdog_timer_timeout,
    input  wire logic       missing_clock_detector_en,
    // Clock and reset control
    output logic            cpu_clk_en,
    output logic            osc_en,
    output logic            wake_irq,
    output logic            sys_reset_req,
    output logic            in_light_sleep,
    output logic            in_deep_sleep,
    // Serial and flag outputs
    output logic            baud_doubler,
    output logic      [4:0] spare_flags
);
    localparam int LOSS_CYC = `CLK_LOSS_TIMEOUT_CYC;

    pwr_state_t  state_r;
    pwr_state_t  state_nxt;
    logic [12:0] loss_cnt_r;
    logic [12:0] loss_cnt_nxt;
    logic        light_req;
    logic        deep_req;
    logic        wake_irq_r;
    logic        wake_irq_nxt;
    logic        rst_req_r;
    logic        rst_req_nxt;
    logic        reset_cause;

    pwr_sfr u_sfr (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .sfr_addr     (sfr_addr),
        .sfr_wr       (sfr_wr),
        .sfr_wdata    (sfr_wdata),
        .sfr_rdata    (sfr_rdata),
        .light_req    (light_req),
        .deep_req     (deep_req),
        .baud_doubler (baud_doubler),
        .spare_flags  (spare_flags)
    );

    assign reset_cause = reset_pin
                         || (watchdog_timer_en && watchdog_timer_timeout);

    //--------------------------------------------------------------
    // Sleep state machine
    //--------------------------------------------------------------
    always_comb begin
        state_nxt    = state_r;
        loss_cnt_nxt = '0;
        wake_irq_nxt = 1'b0;
        rst_req_nxt  = 1'b0;
        unique case (state_r)
            ST_RUN: begin
                if (deep_req) begin
                    state_nxt = ST_DEEP;
                end else if (light_req) begin
                    state_nxt = ST_LIGHT;
                end
            end
            ST_LIGHT: begin
                if (reset_cause) begin
                    state_nxt   = ST_RUN;
                    rst_req_nxt = 1'b1;
                end else if (irq_pending) begin
                    state_nxt    = ST_RUN;
                    wake_irq_nxt = 1'b1;
                end
            end
            ST_DEEP: begin
                if (reset_pin) begin
                    state_nxt   = ST_RUN;
                    rst_req_nxt = 1'b1;
                end else if (missing_clock_detector_en) begin
                    if (32'(loss_cnt_r) >= LOSS_CYC - 1) begin
                        state_nxt   = ST_RUN;
                        rst_req_nxt = 1'b1;
                    end else begin
                        loss_cnt_nxt = loss_cnt_r + 13'h0001;
                    end
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_r    <= ST_RUN;
            loss_cnt_r <= 13'h0000;
            wake_irq_r <= 1'b0;
            rst_req_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            loss_cnt_r <= loss_cnt_nxt;
            wake_irq_r <= wake_irq_nxt;
            rst_req_r  <= rst_req_nxt;
        end
    end

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    // light sleep gates only the CPU clock, deep sleep also the oscillator
    assign cpu_clk_en     = (state_r == ST_RUN);
    assign osc_en         = (state_r != ST_DEEP);
    // core vectors, then returns to next instruction
    assign wake_irq       = wake_irq_r;
    assign sys_reset_req  = rst_req_r;
    assign in_light_sleep = (state_r == ST_LIGHT);
    assign in_deep_sleep  = (state_r == ST_DEEP);

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    sequence s_light_entry;
        state_r == ST_RUN && light_req;
    endsequence

    property p_light_entry;
        @(posedge mclk) disable iff (!rst_b)
        s_light_entry |=> !cpu_clk_en && osc_en;
    endproperty
    a_light_entry: assert property (p_light_entry)
        else $error("light sleep did not gate cpu clock only");

    property p_hold;
        @(posedge mclk) disable iff (!rst_b)
        in_light_sleep && !sfr_wr |=> $stable(sfr_rdata);
    endproperty
    a_hold: assert property (p_hold)
        else $error("register changed in light sleep");

    property p_irq_wake;
        @(posedge mclk) disable iff (!rst_b)
        in_light_sleep && irq_pending && !reset_cause
        |=> cpu_clk_en && wake_irq;
    endproperty
    a_irq_wake: assert property (p_irq_wake)
        else $error("interrupt did not wake light sleep");

    property p_wake_pulse;
        @(posedge mclk) disable iff (!rst_b)
        wake_irq |=> !wake_irq;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake pulse longer than one cycle");

    property p_watchdog;
        @(posedge mclk) disable iff (!rst_b)
        in_light_sleep && watchdog_timer_en && watchdog_timer_timeout
        |=> sys_reset_req && !wake_irq;
    endproperty
    a_watchdog: assert property (p_watchdog)
        else $error("watchdog did not reset light sleep");

    property p_deep_irq;
        @(posedge mclk) disable iff (!rst_b)
        in_deep_sleep && !reset_pin && !missing_clock_detector_en
        |=> in_deep_sleep && !osc_en;
    endproperty
    a_deep_irq: assert property (p_deep_irq)
        else $error("deep sleep left without reset");

    property p_clk_loss;
        @(posedge mclk) disable iff (!rst_b)
        $rose(in_deep_sleep) && missing_clock_detector_en
        ##1 (missing_clock_detector_en && !reset_pin)[*8]
        |-> in_deep_sleep;
    endproperty
    a_clk_loss: assert property (p_clk_loss)
        else $error("detector reset fired too early");

    property p_read_zero;
        @(posedge mclk) disable iff (!rst_b)
        sfr_rdata[1:0] == 2'b00;
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("select bits read nonzero");

    property p_baud;
        @(posedge mclk) disable iff (!rst_b)
        sfr_wr && sfr_addr == `POWER_CONTROL_ADDR
        |=> baud_doubler == $past(sfr_wdata[7]);
    endproperty
    a_baud: assert property (p_baud)
        else $error("baud doubler not written");

    property p_flags;
        @(posedge mclk) disable iff (!rst_b)
        sfr_wr && sfr_addr == `POWER_CONTROL_ADDR
        |=> spare_flags == $past(sfr_wdata[6:2]);
    endproperty
    a_flags: assert property (p_flags)
        else $error("spare flags not written");

    property p_both;
        @(posedge mclk) disable iff (!rst_b)
        state_r == ST_RUN && deep_req |=> in_deep_sleep;
    endproperty
    a_both: assert property (p_both)
        else $error("deep request did not enter deep sleep");

    property p_reset_exit;
        @(posedge mclk) disable iff (!rst_b)
        in_light_sleep && reset_pin |=> sys_reset_req ##1 !sys_reset_req;
    endproperty
    a_reset_exit: assert property (p_reset_exit)
        else $error("reset pin did not end light sleep");
endmodule

// File: rtl/pwr_mode_regs.svh
// Offsets, fields, reset values and timing counts of the power mode block
`ifndef PWR_MODE_REGS_SVH
`define PWR_MODE_REGS_SVH

`define POWER_CONTROL_ADDR  8'h87
`define POWER_CONTROL_RESET 8'h00
`define LIGHT_SLEEP_BIT     0
`define DEEP_SLEEP_BIT      1
`define SPARE_LSB           2
`define SPARE_MSB           6
`define BAUD_DOUBLER_BIT    7
`define CLK_LOSS_TIMEOUT_NS  100000
`define CLK_PERIOD_NS        25
`define CLK_LOSS_TIMEOUT_CYC (`CLK_LOSS_TIMEOUT_NS / `CLK_PERIOD_NS)

`endif

// File: rtl/pwr_mode_pkg.sv
// Types of the power mode block
package pwr_mode_pkg;
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_LIGHT = 3'b010,
        ST_DEEP  = 3'b100
    } pwr_state_t;
endpackage

// File: rtl/pwr_sfr.sv
// Power control register: storage, readback and sleep trigger pulses
`timescale 1ns/1ps
`include "pwr_mode_regs.svh"
module pwr_sfr (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // Decoded fields
    output logic            light_req,
    output logic            deep_req,
    output logic            baud_doubler,
    output logic      [4:0] spare_flags
);
    logic [7:0] store_r;
    logic [7:0] store_nxt;
    logic       hit;

    assign hit = sfr_wr && (sfr_addr == `POWER_CONTROL_ADDR);

    always_comb begin
        store_nxt = store_r;
        if (hit) begin
            store_nxt[7:2] = sfr_wdata[7:2];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            store_r <= `POWER_CONTROL_RESET;
        end else begin
            store_r <= store_nxt;
        end
    end

    assign sfr_rdata = {store_r[7:2], 2'b00};
    assign deep_req  = hit && sfr_wdata[`DEEP_SLEEP_BIT];
    assign light_req = hit && sfr_wdata[`LIGHT_SLEEP_BIT]
                       && !sfr_wdata[`DEEP_SLEEP_BIT];
    assign baud_doubler = store_r[`BAUD_DOUBLER_BIT];
    assign spare_flags  = store_r[`SPARE_MSB:`SPARE_LSB];
endmodule

// File: tb/core_side_model.sv
// Interrupt controller and reset source facing the power mode block
`timescale 1ns/1ps
module core_side_model (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_b,
    // Bench requests
    input  wire logic irq_src,
    input  wire logic rst_src,
    // Block feedback
    input  wire logic wake_irq,
    input  wire logic sys_reset_req,
    // Toward the block
    output logic      irq_pending,
    output logic      reset_pin
);
    logic irq_r;
    logic irq_nxt;
    logic pin_r;
    logic pin_nxt;

    always_comb begin
        irq_nxt = (irq_r | irq_src) & ~wake_irq & ~sys_reset_req;
        pin_nxt = (pin_r | rst_src) & ~sys_reset_req;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
            pin_r <= pin_nxt;
        end
    end

    assign irq_pending = irq_r;
    assign reset_pin   = pin_r;
endmodule

// File: tb/test_cpu_power_mode_control.sv
// Self-checking bench for the processor power mode block
`timescale 1ns/1ps
`include "pwr_mode_regs.svh"
module test_cpu_power_mode_control;
    logic       mclk;
    logic       rst_b;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       irq_pending;
    logic       reset_pin;
    logic       watchdog_timer_en;
    logic       watchdog_timer_timeout;
    logic       missing_clock_detector_en;
    logic       cpu_clk_en;
    logic       osc_en;
    logic       wake_irq;
    logic       sys_reset_req;
    logic       in_light_sleep;
    logic       in_deep_sleep;
    logic       baud_doubler;
    logic [4:0] spare_flags;
    logic       irq_src;
    logic       rst_src;
    int         n_errors = 0;
    int         checks = 0;
    int         cycles = 0;
    int         cnt;

    cpu_power_mode_control cpu_power_mode_control_i (
        .mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .irq_pending(irq_pending), .reset_pin(reset_pin),
        .watchdog_timer_en(watchdog_timer_en),
        .watchdog_timer_timeout(watchdog_timer_timeout),
        .missing_clock_detector_en(missing_clock_detector_en),
        .cpu_clk_en(cpu_clk_en), .osc_en(osc_en), .wake_irq(wake_irq),
        .sys_reset_req(sys_reset_req), .in_light_sleep(in_light_sleep),
        .in_deep_sleep(in_deep_sleep), .baud_doubler(baud_doubler),
        .spare_flags(spare_flags));

    core_side_model core_side_model_i (
        .mclk(mclk), .rst_b(rst_b), .irq_src(irq_src), .rst_src(rst_src),
        .wake_irq(wake_irq), .sys_reset_req(sys_reset_req),
        .irq_pending(irq_pending), .reset_pin(reset_pin));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic wrap_up();
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge mclk);
        sfr_wr <= 1'b0;
        #1;
    endtask

    task automatic kick(input bit on_reset);
        @(posedge mclk);
        if (on_reset) rst_src <= 1'b1;
        else irq_src <= 1'b1;
        @(posedge mclk);
        rst_src <= 1'b0;
        irq_src <= 1'b0;
    endtask

    task automatic wait_for(input bit on_reset, input int limit);
        logic hit;
        cnt = 0;
        hit = 1'b0;
        while (hit !== 1'b1 && cnt < limit) begin
            @(posedge mclk);
            #1;
            cnt++;
            hit = on_reset ? sys_reset_req : wake_irq;
        end
        check("exit pulse", {7'h00, hit}, 8'h01);
    endtask

    // ----------------------------------------
    // Clock, timeout and main sequence
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        rst_b = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        watchdog_timer_en = 1'b0;
        watchdog_timer_timeout = 1'b0;
        missing_clock_detector_en = 1'b0;
        irq_src = 1'b0;
        rst_src = 1'b0;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        check("reset reg", sfr_rdata, 8'h00);
        check("reset state", {in_deep_sleep, cpu_clk_en, osc_en},
              8'h03);
        write(`POWER_CONTROL_ADDR, 8'hFC);
        check("flags", sfr_rdata, 8'hFC);
        check("doubler", {7'h00, baud_doubler}, 8'h01);
        write(8'h86, 8'h00);
        check("unmapped", sfr_rdata, 8'hFC);
        write(`POWER_CONTROL_ADDR, 8'h55);
        check("light", {in_light_sleep, cpu_clk_en, osc_en}, 8'h05);
        check("kept flags", {3'h0, spare_flags}, 8'h15);
        check("select read", sfr_rdata, 8'h54);
        check("doubler off", {7'h00, baud_doubler}, 8'h00);
        kick(1'b0);
        wait_for(1'b0, 10);
        check("irq wake", {in_light_sleep, cpu_clk_en}, 8'h01);
        check("no reset", {7'h00, sys_reset_req}, 8'h00);
        check("kept reg", sfr_rdata, 8'h54);
        write(`POWER_CONTROL_ADDR, 8'h01);
        @(posedge mclk);
        watchdog_timer_timeout <= 1'b1;
        repeat (5) @(posedge mclk);
        #1;
        check("watchdog off", {7'h00, in_light_sleep}, 8'h01);
        @(posedge mclk);
        watchdog_timer_en <= 1'b1;
        wait_for(1'b1, 10);
        check("watchdog exit", {in_light_sleep, cpu_clk_en}, 8'h01);
        @(posedge mclk);
        watchdog_timer_en <= 1'b0;
        watchdog_timer_timeout <= 1'b0;
        write(`POWER_CONTROL_ADDR, 8'h01);
        kick(1'b1);
        wait_for(1'b1, 10);
        check("pin exit", {in_light_sleep, cpu_clk_en}, 8'h01);
        write(`POWER_CONTROL_ADDR, 8'h03);
        check("deep", {in_deep_sleep, in_light_sleep, osc_en, cpu_clk_en},
              8'h08);
        kick(1'b0);
        repeat (20) @(posedge mclk);
        #1;
        check("irq in deep", {in_deep_sleep, cpu_clk_en}, 8'h02);
        kick(1'b1);
        wait_for(1'b1, 10);
        check("deep exit", {in_deep_sleep, osc_en}, 8'h01);
        @(posedge mclk);
        missing_clock_detector_en <= 1'b1;
        write(`POWER_CONTROL_ADDR, 8'h02);
        wait_for(1'b1, `CLK_LOSS_TIMEOUT_CYC + 100);
        check("detector time", {7'h00, (cnt >= `CLK_LOSS_TIMEOUT_CYC - 2 &&
              cnt <= `CLK_LOSS_TIMEOUT_CYC + 2)}, 8'h01);
        @(posedge mclk);
        missing_clock_detector_en <= 1'b0;
        write(`POWER_CONTROL_ADDR, 8'h02);
        repeat (`CLK_LOSS_TIMEOUT_CYC + 100) @(posedge mclk);
        #1;
        check("detector off", {7'h00, in_deep_sleep}, 8'h01);
        kick(1'b1);
        wait_for(1'b1, 10);
        wrap_up();
    end
endmodule
